// ---- logic/lvs_pkg.sv ----
// Shared constants and types for the serial lane block
package lvs_pkg;
   // Clock and timing
   localparam int unsigned CLK_PERIOD_PS  = 50000;
   localparam int unsigned DLY_STEP_PS    = 25;
   localparam int unsigned DLY_MAX_STEPS  = 63;
   localparam int unsigned DLY_CYC        =
      (DLY_MAX_STEPS * DLY_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned LINK_MAX_MBPS  = 600;
   localparam int unsigned LINK_MIN_PS    = 1000000 / LINK_MAX_MBPS;
   localparam int unsigned LINK_MIN_CYC_R =
      (LINK_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned LINK_MIN_CYC   =
      (LINK_MIN_CYC_R < 1) ? 1 : LINK_MIN_CYC_R;
   // Word widths
   localparam int unsigned WORD_MAX   = 8;
   localparam logic [3:0]  WIDTH_MIN  = 4'h2;
   localparam logic [3:0]  WIDTH_MAX  = 4'h8;
   localparam int unsigned FIFO_DEPTH = 16;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_TXDATA = 8'h04;
   localparam logic [7:0] ADDR_RXDATA = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_NONE   = 8'hFF;
   // Control field positions
   localparam int unsigned CTRL_TXW    = 0;
   localparam int unsigned CTRL_RXW    = 4;
   localparam int unsigned CTRL_TXSER  = 8;
   localparam int unsigned CTRL_TXFWD  = 9;
   localparam int unsigned CTRL_DIV2   = 10;
   localparam int unsigned CTRL_BLVL   = 11;
   localparam int unsigned CTRL_BOE    = 12;
   localparam int unsigned CTRL_RXDES  = 13;
   localparam int unsigned CTRL_RXPLL  = 14;
   localparam int unsigned CTRL_DLY    = 16;
   localparam logic [31:0] CTRL_RESET  = 32'h0000_2188;
   // Status field positions
   localparam int unsigned STAT_FULL   = 5;
   localparam int unsigned STAT_EMPTY  = 6;
   localparam int unsigned STAT_RXNEW  = 7;
   // Transmit lane mode
   typedef enum logic [2:0] {
      LVS_TX_SER = 3'b001,
      LVS_TX_FWD = 3'b010,
      LVS_TX_BUF = 3'b100
   } lvs_txmode_t;
endpackage

// ---- logic/lvs_serdes_lanes.sv ----
// Serial lane pair with word FIFO and AHB-Lite register slave
module lvs_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             clock,
   input  wire logic             srst,
   input  wire logic             clk_en,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int unsigned PW = $clog2(DEPTH);
   localparam int unsigned CW = $clog2(DEPTH+1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_q;
   logic [PW-1:0]    rd_q;
   logic [CW-1:0]    cnt_q;
   wire              push = in_valid & in_ready & clk_en;
   wire              pop  = out_valid & out_ready & clk_en;

   assign in_ready  = (cnt_q != FULL_CNT);
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign level     = cnt_q;

   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == LAST_PTR) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == LAST_PTR) ? '0 : rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // lvs_fifo

////////////////////////////////////////////////////////////////////////
module lvs_serdes_lanes #(
   parameter int unsigned WORD_W     = lvs_pkg::WORD_MAX,
   parameter int unsigned FIFO_DEPTH = lvs_pkg::FIFO_DEPTH
) (
   input  wire logic              clock,
   input  wire logic              srst,
   input  wire logic              clk_en,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   input  wire logic              serial_bit_clock,
   input  wire logic              parallel_word_clock,
   output logic                   tx_pad_positive,
   output logic                   tx_pad_negative,
   output logic                   tx_pad_oe,
   input  wire logic              rx_pad_positive,
   input  wire logic              rx_pad_negative,
   output logic [WORD_W-1:0]      rx_word,
   output logic                   rx_word_valid,
   output logic                   rx_bypass_clock_tap
);
   localparam int unsigned CW = $clog2(FIFO_DEPTH+1);

   // Clamp a width field into the supported range
   function automatic logic [3:0] ratio_of(input logic [3:0] f);
      if (f < lvs_pkg::WIDTH_MIN) begin
         ratio_of = lvs_pkg::WIDTH_MIN;
      end else if (f > lvs_pkg::WIDTH_MAX) begin
         ratio_of = lvs_pkg::WIDTH_MAX;
      end else begin
         ratio_of = f;
      end
   endfunction

   logic [3:0]        sync_m_q;
   logic [3:0]        sync_s_q;
   logic [1:0]        link_prev_q;
   logic              dph_valid_q;
   logic              dph_write_q;
   logic [7:0]        dph_addr_q;
   logic [31:0]       hrdata_q;
   logic [31:0]       ctrl_q;
   logic [WORD_W-1:0] tx_sh_q;
   logic [WORD_W-1:0] tx_sh_d;
   logic              tx_out_q;
   logic              tx_out_d;
   logic              tx_oe_q;
   logic              tx_oe_d;
   logic              div_q;
   logic              div_d;
   logic              rx_bit_q;
   logic              rx_dly_q;
   logic [WORD_W-1:0] rx_sh_q;
   logic [WORD_W-1:0] rx_sh_d;
   logic [WORD_W-1:0] rx_word_q;
   logic [WORD_W-1:0] rx_word_d;
   logic              rx_valid_q;
   logic              rx_valid_d;
   logic              rx_flag_q;
   logic              rx_tap_q;
   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic              fifo_out_ready;
   logic [WORD_W-1:0] fifo_out_data;
   logic [CW-1:0]     fifo_level;
   logic [31:0]       rd_mux;
   lvs_pkg::lvs_txmode_t tx_mode;

   ////////////////////////////////////////////////////////////////////
   // Link inputs: two flops, then edge detection on the second stage
   always_ff @(posedge clock) begin
      if (srst) begin
         sync_m_q <= 4'h0;
         sync_s_q <= 4'h0;
      end else if (clk_en) begin
         sync_m_q <= {rx_pad_negative, rx_pad_positive,
                      parallel_word_clock, serial_bit_clock};
         sync_s_q <= sync_m_q;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         link_prev_q <= 2'h0;
      end else if (clk_en) begin
         link_prev_q <= sync_s_q[1:0];
      end
   end

   wire bclk_s    = sync_s_q[0];
   wire wclk_s    = sync_s_q[1];
   wire rxp_s     = sync_s_q[2];
   wire rxn_s     = sync_s_q[3];
   // Both edges come from equal-depth synchronisers, so a word edge
   // lands in the same cycle as its bit edge
   wire bit_edge  = bclk_s & ~link_prev_q[0];
   wire word_edge = wclk_s & ~link_prev_q[1];

   ////////////////////////////////////////////////////////////////////
   // AHB-Lite slave
   wire       addr_ok = hsel & hready & htrans[1];
   wire       in_page = (haddr[31:8] == 24'h0);
   wire [7:0] a_dec   = in_page ? haddr[7:0] : lvs_pkg::ADDR_NONE;
   wire       wr_now  = dph_valid_q & dph_write_q;
   wire       wr_ctrl = wr_now & (dph_addr_q == lvs_pkg::ADDR_CTRL);
   wire       wr_tx   = wr_now & (dph_addr_q == lvs_pkg::ADDR_TXDATA);
   wire       rd_rx   = addr_ok & ~hwrite & hreadyout
                        & (a_dec == lvs_pkg::ADDR_RXDATA);
   wire [31:0] status = {{(32-lvs_pkg::STAT_RXNEW-1){1'b0}}, rx_flag_q,
                         ~fifo_out_valid, ~fifo_in_ready,
                         (5)'(fifo_level)};

   // A word write into a full FIFO holds the bus until room appears
   assign hreadyout = ~(wr_tx & ~fifo_in_ready);
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;
   assign rd_mux    =
      (a_dec == lvs_pkg::ADDR_CTRL)   ? ctrl_q :
      (a_dec == lvs_pkg::ADDR_RXDATA) ? 32'(rx_word_q) :
      (a_dec == lvs_pkg::ADDR_STATUS) ? status : 32'h0000_0000;

   always_ff @(posedge clock) begin
      if (srst) begin
         dph_valid_q <= 1'b0;
         dph_write_q <= 1'b0;
         dph_addr_q  <= 8'h00;
         hrdata_q    <= 32'h0000_0000;
      end else if (clk_en && hreadyout) begin
         dph_valid_q <= addr_ok;
         dph_write_q <= hwrite;
         dph_addr_q  <= a_dec;
         if (addr_ok && !hwrite) begin
            hrdata_q <= rd_mux;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         ctrl_q <= lvs_pkg::CTRL_RESET;
      end else if (clk_en && wr_ctrl) begin
         ctrl_q <= hwdata;
      end
   end

   // Static lane settings
   wire [3:0] tx_w     = ratio_of(ctrl_q[lvs_pkg::CTRL_TXW +: 4]);
   wire [3:0] rx_w     = ratio_of(ctrl_q[lvs_pkg::CTRL_RXW +: 4]);
   wire       tx_ser   = ctrl_q[lvs_pkg::CTRL_TXSER];
   wire       tx_fwd   = ctrl_q[lvs_pkg::CTRL_TXFWD];
   wire       div2     = ctrl_q[lvs_pkg::CTRL_DIV2];
   wire       byp_lvl  = ctrl_q[lvs_pkg::CTRL_BLVL];
   wire       byp_oe   = ctrl_q[lvs_pkg::CTRL_BOE];
   wire       rx_deser = ctrl_q[lvs_pkg::CTRL_RXDES];
   wire       rx_pll   = ctrl_q[lvs_pkg::CTRL_RXPLL];
   wire [5:0] rx_dly   = ctrl_q[lvs_pkg::CTRL_DLY +: 6];

   ////////////////////////////////////////////////////////////////////
   // Transmit word buffer
   lvs_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .srst      (srst),
      .clk_en    (clk_en),
      .in_valid  (wr_tx),
      .in_ready  (fifo_in_ready),
      .in_data   (hwdata[WORD_W-1:0]),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data),
      .level     (fifo_level)
   );

   ////////////////////////////////////////////////////////////////////
   // Transmit lane
   wire [WORD_W-1:0] tx_mask = WORD_W'(8'hFF >> (4'h8 - tx_w));
   // Bits above the chosen width are dropped from each word
   wire [WORD_W-1:0] tx_load = fifo_out_valid ?
                               (fifo_out_data & tx_mask) : '0;

   assign tx_mode = tx_fwd ? lvs_pkg::LVS_TX_FWD :
                    tx_ser ? lvs_pkg::LVS_TX_SER : lvs_pkg::LVS_TX_BUF;

   always_comb begin
      tx_sh_d        = tx_sh_q;
      tx_out_d       = tx_out_q;
      tx_oe_d        = 1'b1;
      div_d          = div_q;
      fifo_out_ready = 1'b0;
      case (tx_mode)
         lvs_pkg::LVS_TX_SER: begin
            if (word_edge) begin
               fifo_out_ready = 1'b1;
               tx_sh_d        = tx_load;
               tx_out_d       = tx_load[0];
            end else if (bit_edge) begin
               tx_sh_d  = tx_sh_q >> 1;
               tx_out_d = tx_sh_q[1];
            end
         end
         lvs_pkg::LVS_TX_FWD: begin
            // Pattern changes on the same cycle a data lane loads
            if (div2) begin
               if (word_edge) begin
                  div_d    = ~div_q;
                  tx_out_d = ~div_q;
               end
            end else begin
               tx_out_d = wclk_s;
            end
         end
         lvs_pkg::LVS_TX_BUF: begin
            tx_out_d = byp_lvl;
            tx_oe_d  = byp_oe;
         end
         default: begin
            tx_out_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         tx_sh_q  <= '0;
         tx_out_q <= 1'b0;
         tx_oe_q  <= 1'b1;
         div_q    <= 1'b0;
      end else if (clk_en) begin
         tx_sh_q  <= tx_sh_d;
         tx_out_q <= tx_out_d;
         tx_oe_q  <= tx_oe_d;
         div_q    <= div_d;
      end
   end

   assign tx_pad_positive = tx_out_q;
   assign tx_pad_negative = ~tx_out_q;
   assign tx_pad_oe       = tx_oe_q;

   ////////////////////////////////////////////////////////////////////
   // Receive lane
   // An undriven pair (both legs equal) keeps the last resolved bit
   wire rx_raw = (rxp_s != rxn_s) ? rxp_s : rx_bit_q;
   // Whole setting range is below one clock, so any step is one flop
   wire rx_bit = (rx_dly != 6'h00) ? rx_dly_q : rx_bit_q;

   always_comb begin
      rx_sh_d    = bit_edge ? {rx_bit, rx_sh_q[WORD_W-1:1]} : rx_sh_q;
      rx_word_d  = rx_word_q;
      rx_valid_d = 1'b0;
      if (!rx_deser) begin
         rx_word_d = WORD_W'(rx_bit);
      end else if (word_edge) begin
         rx_word_d  = rx_sh_d >> (4'h8 - rx_w);
         rx_valid_d = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         rx_bit_q   <= 1'b0;
         rx_dly_q   <= 1'b0;
         rx_sh_q    <= '0;
         rx_word_q  <= '0;
         rx_valid_q <= 1'b0;
         rx_flag_q  <= 1'b0;
         rx_tap_q   <= 1'b0;
      end else if (clk_en) begin
         rx_bit_q   <= rx_raw;
         rx_dly_q   <= rx_bit_q;
         rx_sh_q    <= rx_sh_d;
         rx_word_q  <= rx_word_d;
         rx_valid_q <= rx_valid_d;
         // A new word in the cycle of a read keeps the flag set
         rx_flag_q  <= rx_valid_d | (rx_flag_q & ~rd_rx);
         rx_tap_q   <= ~rx_deser & rx_pll & rx_bit;
      end
   end

   assign rx_word             = rx_word_q;
   assign rx_word_valid       = rx_valid_q;
   assign rx_bypass_clock_tap = rx_tap_q;

   ////////////////////////////////////////////////////////////////////
   // Checks
   logic [3:0] gap_q;
   always_ff @(posedge clock) begin
      if (srst || (clk_en && bit_edge)) begin
         gap_q <= 4'h0;
      end else if (clk_en && gap_q != 4'hF) begin
         gap_q <= gap_q + 4'h1;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   sequence s_word_load;
      clk_en && word_edge && tx_mode == lvs_pkg::LVS_TX_SER;
   endsequence
   sequence s_bit_shift;
      clk_en && bit_edge && !word_edge
         && tx_mode == lvs_pkg::LVS_TX_SER;
   endsequence

   a_tx_word_load: assert property (s_word_load |=>
      tx_sh_q == $past(tx_load) && tx_out_q == $past(tx_load[0]))
      else $error("word not loaded on word clock edge");
   a_tx_bit_shift: assert property (s_bit_shift |=>
      tx_out_q == $past(tx_sh_q[1]) && !tx_sh_q[WORD_W-1])
      else $error("serial bit not shifted on bit edge");
   a_fwd_half_rate: assert property (clk_en && word_edge
      && tx_mode == lvs_pkg::LVS_TX_FWD && div2
      |=> tx_out_q != $past(tx_out_q))
      else $error("divided forwarded clock did not toggle");
   a_fwd_full_rate: assert property (clk_en
      && tx_mode == lvs_pkg::LVS_TX_FWD && !div2
      |=> tx_out_q == $past(wclk_s))
      else $error("forwarded clock not aligned to word edge");
   a_tx_plain_buf: assert property (clk_en
      && tx_mode == lvs_pkg::LVS_TX_BUF |=> tx_out_q == $past(byp_lvl)
      && tx_pad_oe == $past(byp_oe))
      else $error("bypass output buffer level or enable wrong");
   a_rx_word_out: assert property (clk_en && word_edge
      && rx_deser |=> rx_word_valid && rx_word == $past(rx_word_d)
      ##1 (!rx_word_valid || !$past(clk_en) || $past(word_edge)))
      else $error("receive word not delivered on word edge");
   a_rx_plain_in: assert property (clk_en && !rx_deser
      |=> rx_word == WORD_W'($past(rx_bit)) && !rx_word_valid)
      else $error("bypass input level not passed through");
   a_clock_tap: assert property (rx_bypass_clock_tap
      |-> $past(!rx_deser && rx_pll))
      else $error("clock tap driven outside pll bypass");
   a_bit_rate: assert property (clk_en && bit_edge
      |-> gap_q >= 4'(lvs_pkg::LINK_MIN_CYC) - 4'h1)
      else $error("bit edges closer than lane rate allows");
   a_bus_stall: assert property (wr_tx && !fifo_in_ready
      |-> !hreadyout)
      else $error("write to full buffer not stalled");
endmodule // lvs_serdes_lanes

// ---- dv/lvs_link_partner.sv ----
// Far-end link model: bit and word clocks, receive pads, transmit capture
module lvs_link_partner (
   output logic      serial_bit_clock,
   output logic      parallel_word_clock,
   output logic      rx_pad_positive,
   output logic      rx_pad_negative,
   input  wire logic tx_pad_positive
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] rx_words[$];
   logic [7:0] tx_got[$];
   logic [7:0] acc;
   logic       bit_v;
   initial begin
      serial_bit_clock = 1'h0;
      parallel_word_clock = 1'h0;
      rx_pad_positive = 1'h1;
      rx_pad_negative = 1'h0;
   end
   ////////////////////////////////////////////////////////////
   // Legs stay opposite; equal legs would be ignored by the lane
   task automatic set_level(input logic lvl);
      rx_pad_positive = lvl;
      rx_pad_negative = ~lvl;
   endtask
   // Burst of nw words of w bits, 400 ns per bit, LSB first
   task automatic frame(input int nw, input int w);
      tx_got.delete();
      acc = 8'h00;
      // Keep every link change clear of the system clock edges
      #10;
      for (int n = 0; n <= nw * w; n++) begin
         if (n > 0) begin
            bit_v = ((n - 1) / w < rx_words.size()) ?
                    rx_words[(n - 1) / w][(n - 1) % w] : 1'h0;
            set_level(bit_v);
         end
         #200;
         serial_bit_clock = 1'h1;
         parallel_word_clock = (n % w == 0);
         if (n > 0) acc[(n - 1) % w] = tx_pad_positive;
         if (n > 0 && n % w == 0) begin
            tx_got.push_back(acc);
            acc = 8'h00;
         end
         #200;
         serial_bit_clock = 1'h0;
      end
      // Clocks stand still between bursts and the line flips to the opposite level
      parallel_word_clock = 1'h0;
      set_level(~rx_pad_positive);
   endtask
endmodule // lvs_link_partner

// ---- dv/tb_lvs_serdes_lanes.sv ----
// Self-checking bench for the serial lane block
module tb_lvs_serdes_lanes;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [31:0] ctrl;
      logic        lvl;
      logic        cpad;
      logic        pad;
      logic        oe;
      logic        tap;
   } lvs_row_t;
   logic        clock, srst, clk_en, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd, ctrl, mask;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        serial_bit_clock, parallel_word_clock;
   logic        tx_pad_positive, tx_pad_negative, tx_pad_oe;
   logic        rx_pad_positive, rx_pad_negative;
   logic        rx_word_valid, rx_bypass_clock_tap;
   logic [7:0]  rx_word;
   logic [7:0]  tv[3];
   logic [7:0]  rxq[$];
   int          miscompares, samples_checked, tog;
   // Control word, pad level in, then pad check flag, pad, oe, tap
   lvs_row_t    rows[5] = '{
      '{32'h0000_1888, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0},
      '{32'h0000_0088, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0},
      '{32'h003F_4888, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1},
      '{32'h0000_5088, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0},
      '{32'h0000_6188, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0}};
   lvs_serdes_lanes uut (
      .clock, .srst, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .serial_bit_clock, .parallel_word_clock, .tx_pad_positive,
      .tx_pad_negative, .tx_pad_oe, .rx_pad_positive, .rx_pad_negative,
      .rx_word, .rx_word_valid, .rx_bypass_clock_tap);
   lvs_link_partner ptn (
      .serial_bit_clock, .parallel_word_clock, .rx_pad_positive,
      .rx_pad_negative, .tx_pad_positive);
   ////////////////////////////////////////////////////////////
   initial begin
      clock = 1'h0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock) if (rx_word_valid === 1'h1) rxq.push_back(rx_word);
   always @(tx_pad_positive) tog++;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Single word transfer; an idle cycle precedes each address phase
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge clock);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge clock); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hsel <= 1'h0;
      hwdata <= wd;
      do @(posedge clock); while (hreadyout !== 1'h1);
      rd = hrdata;
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      srst = 1'h1;
      clk_en = 1'h1;
      hsel = 1'h0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (16) @(posedge clock);
      srst <= 1'h0;
      @(posedge clock);
      check({hresp, tx_pad_positive, tx_pad_negative, tx_pad_oe,
             rx_bypass_clock_tap, rx_word_valid}, 32'h0C);
      bus(1'h0, lvs_pkg::ADDR_CTRL, 32'h0);
      check(rd, lvs_pkg::CTRL_RESET);
      bus(1'h0, lvs_pkg::ADDR_STATUS, 32'h0);
      check(rd, 32'h40);
      // Unmapped writes must not alias onto the control word
      bus(1'h1, 8'h20, 32'hFFFF_FFFF);
      bus(1'h0, 8'h20, 32'h0);
      check(rd, 32'h0);
      bus(1'h0, lvs_pkg::ADDR_TXDATA, 32'h0);
      check(rd, 32'h0);
      // A write while the clock enable is low must be dropped
      clk_en <= 1'h0;
      bus(1'h1, lvs_pkg::ADDR_CTRL, 32'h0);
      clk_en <= 1'h1;
      bus(1'h0, lvs_pkg::ADDR_CTRL, 32'h0);
      check(rd, lvs_pkg::CTRL_RESET);
      $display("test reset done");
      foreach (rows[i]) begin
         bus(1'h1, lvs_pkg::ADDR_CTRL, rows[i].ctrl);
         #10 ptn.set_level(rows[i].lvl);
         repeat (6) @(posedge clock);
         bus(1'h0, lvs_pkg::ADDR_CTRL, 32'h0);
         check(rd & 32'h003F_7FFF, rows[i].ctrl);
         if (rows[i].cpad)
            check({tx_pad_positive, tx_pad_negative},
                  {rows[i].pad, ~rows[i].pad});
         check(tx_pad_oe, rows[i].oe);
         check(rx_bypass_clock_tap, rows[i].tap);
      end
      $display("test buffer rows done");
      for (int w = 2; w <= 8; w++) begin
         mask = (32'h1 << w) - 32'h1;
         ctrl = 32'h2100 | w | (w << 4) | (w[0] ? 32'h003F_0000 : 32'h0);
         bus(1'h1, lvs_pkg::ADDR_CTRL, ctrl);
         ptn.rx_words.delete();
         for (int k = 0; k < 3; k++) begin
            tv[k] = 8'hA5 + 8'h3C * k;
            bus(1'h1, lvs_pkg::ADDR_TXDATA, {24'h0, tv[k]});
            ptn.rx_words.push_back(8'h5A ^ (8'h27 * k));
         end
         rxq.delete();
         ptn.frame(3, w);
         repeat (8) @(posedge clock);
         check(rxq.size(), 32'h4);
         for (int k = 0; k < 3; k++) begin
            check(ptn.tx_got[k], tv[k] & mask);
            check(rxq[k + 1] & mask, ptn.rx_words[k] & mask);
         end
         bus(1'h0, lvs_pkg::ADDR_STATUS, 32'h0);
         check(rd[7:0], 8'hC0);
         bus(1'h0, lvs_pkg::ADDR_RXDATA, 32'h0);
         check(rd & mask, ptn.rx_words[2] & mask);
         bus(1'h0, lvs_pkg::ADDR_STATUS, 32'h0);
         check(rd[7:0], 8'h40);
         $display("test width %0d done", w);
      end
      // Fill the buffer, stall one more write, then drain it all
      bus(1'h1, lvs_pkg::ADDR_CTRL, 32'h0000_2188);
      for (int i = 0; i < 16; i++)
         bus(1'h1, lvs_pkg::ADDR_TXDATA, 32'h11 * i + 1);
      bus(1'h0, lvs_pkg::ADDR_STATUS, 32'h0);
      check(rd[5:0], 6'h30);
      fork
         bus(1'h1, lvs_pkg::ADDR_TXDATA, 32'hC3);
         begin
            repeat (6) @(posedge clock);
            check(hreadyout, 1'h0);
            ptn.frame(17, 8);
         end
      join
      repeat (8) @(posedge clock);
      for (int i = 0; i < 17; i++)
         check(ptn.tx_got[i], (i < 16) ? 8'(8'h11 * i + 1) : 8'hC3);
      bus(1'h0, lvs_pkg::ADDR_STATUS, 32'h0);
      check(rd[6:0], 7'h40);
      $display("test fill and drain done");
      for (int d = 0; d < 2; d++) begin
         bus(1'h1, lvs_pkg::ADDR_CTRL, 32'h0244 | (d << 10));
         repeat (8) @(posedge clock);
         tog = 0;
         ptn.frame(4, 4);
         repeat (8) @(posedge clock);
         check(tog, d ? 32'h5 : 32'hA);
      end
      $display("test forwarded clock done");
      results();
   end
   initial begin
      #400000;
      miscompares++;
      results();
   end
endmodule // tb_lvs_serdes_lanes
